/* File: rtl/rvs_verify_cmd.sv */
// Our own choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// Functional notes
// - A verify reads and checks each sector on the media and moves no sector data to the host.
// - Command codes 40h and 41h written to the command register start the 28-bit verify.
// - Bit 0 of the 28-bit code is a retry flag that is ignored, so both codes act alike.
// - Code 42h starts the 48-bit verify once both taskfile halves are loaded.
// - An uncorrectable sector stops the verify there and no later sector is checked.
// - The 28-bit form verifies the 8-bit sector count of sectors, zero meaning 256.
// - In logical mode the start address is sector number, cylinder low, high and head nibble.
// - In CHS mode the start is cylinder, head nibble and sector number.
// - On completion the sector count holds the sectors not verified, zero unless stopped.
// - The 28-bit form returns the last handled sector's address in the same address mode.
// - Only the uncorrectable, ID-not-found and abort error bits may ever be set.
// - At completion BSY, DF and COR are clear while RDY, DSC and ERR are valid.
// - The 48-bit count is current bits 7:0 and previous bits 15:8, zero meaning 65,536.
// - After a 48-bit failure the failing address reads low bytes with HOB clear, high with it set.
module rvs_verify_cmd
	import rvs_pkg::*;
(
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rstn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// Interrupt
	output logic             irq,
	// Drive pins
	input  wire logic        drive_ready_pin,
	input  wire logic        seek_done_pin,
	// Media check engine
	output logic             media_req,
	output logic [47:0]      media_addr,
	output logic             media_chs,
	input  wire logic        media_done,
	input  wire logic        media_unc,
	input  wire logic        media_idnf
);
	// ************************************************************
	// Declarations
	// ************************************************************
	rvs_state_t  state_q;
	logic        bsy_q;
	logic        ext_q;
	logic        chs_q;
	logic [47:0] addr_q;
	logic [16:0] rem_q;
	logic [7:0]  err_q;
	logic [7:0]  cnt_cur_q;
	logic [7:0]  cnt_prev_q;
	logic [7:0]  sn_cur_q;
	logic [7:0]  sn_prev_q;
	logic [7:0]  cl_cur_q;
	logic [7:0]  cl_prev_q;
	logic [7:0]  ch_cur_q;
	logic [7:0]  ch_prev_q;
	logic [7:0]  devhead_q;
	logic [7:0]  devctl_q;
	logic [15:0] geom_q;
	logic [1:0]  irq_stat_q;
	logic [1:0]  irq_mask_q;
	logic [31:0] hrdata_q;
	logic        wr_pend_q;
	logic [7:0]  wr_addr_q;
	logic        rdy_s;
	logic        dsc_s;
	logic        ap_valid;
	logic        rd_take;
	logic        tf_wr;
	logic        cmd_wr;
	logic [7:0]  wbyte;
	logic        go28;
	logic        go48;
	logic        go_abort;
	logic [7:0]  status_byte;
	logic [7:0]  rd_byte;
	logic        hob;
	logic [1:0]  irq_set;
	logic [1:0]  irq_clr;

	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	rvs_sync3 u_sync_rdy (
		.ref_clk   (ref_clk),
		.rstn      (rstn),
		.pin_in    (drive_ready_pin),
		.level_out (rdy_s)
	);

	rvs_sync3 u_sync_dsc (
		.ref_clk   (ref_clk),
		.rstn      (rstn),
		.pin_in    (seek_done_pin),
		.level_out (dsc_s)
	);

	// ************************************************************
	// AHB-Lite slave
	// ************************************************************
	// Zero wait states; every access answers OKAY, size is not checked
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_q;
	assign ap_valid  = hsel && htrans[1] && hready;
	assign rd_take   = ap_valid && !hwrite;
	assign wbyte     = hwdata[7:0];
	assign hob       = devctl_q[RVS_DC_HOB];

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
		end else begin
			wr_pend_q <= ap_valid && hwrite;
			wr_addr_q <= haddr[7:0];
		end
	end

	// Taskfile is frozen while busy so taskfile writes cannot disturb a verify in flight; geometry writes still land
	assign tf_wr  = wr_pend_q && !bsy_q;
	assign cmd_wr = tf_wr && (wr_addr_q == RVS_OFS_CMD);
	assign go28     = cmd_wr && (wbyte[7:1] == RVS_CMD_VERIFY28_HI);
	assign go48     = cmd_wr && (wbyte == RVS_CMD_VERIFY48);
	assign go_abort = cmd_wr && !go28 && !go48;

	// RDY and DSC follow the pins; DF, COR and the data bits never set
	assign status_byte = {bsy_q, rdy_s, 1'b0, dsc_s, 1'b0, 1'b0, 1'b0, |err_q};

	always_comb begin
		rd_byte = 8'h00;
		unique case (haddr[7:0])
			RVS_OFS_SECCNT:   rd_byte = hob ? cnt_prev_q : cnt_cur_q;
			RVS_OFS_SECNUM:   rd_byte = hob ? sn_prev_q : sn_cur_q;
			RVS_OFS_CYLLO:    rd_byte = hob ? cl_prev_q : cl_cur_q;
			RVS_OFS_CYLHI:    rd_byte = hob ? ch_prev_q : ch_cur_q;
			RVS_OFS_DEVHEAD:  rd_byte = devhead_q;
			RVS_OFS_CMD:      rd_byte = status_byte;
			RVS_OFS_ERROR:    rd_byte = err_q;
			RVS_OFS_DEVCTL:   rd_byte = devctl_q;
			RVS_OFS_IRQ_STAT: rd_byte = {6'h00, irq_stat_q};
			RVS_OFS_IRQ_MASK: rd_byte = {6'h00, irq_mask_q};
			RVS_OFS_GEOM:     rd_byte = geom_q[7:0];
			default:          rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			hrdata_q <= 32'h00000000;
		end else if (rd_take) begin
			if (haddr[7:0] == RVS_OFS_GEOM) begin
				hrdata_q <= {16'h0000, geom_q};
			end else begin
				hrdata_q <= {24'h000000, rd_byte};
			end
		end
	end

	// ************************************************************
	// Control registers
	// ************************************************************
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			devctl_q   <= 8'h00;
			irq_mask_q <= 2'h0;
			geom_q     <= RVS_RST_GEOM;
		end else if (wr_pend_q) begin
			if (wr_addr_q == RVS_OFS_DEVCTL) begin
				devctl_q <= wbyte;
			end
			if (wr_addr_q == RVS_OFS_IRQ_MASK) begin
				irq_mask_q <= hwdata[1:0];
			end
			if (wr_addr_q == RVS_OFS_GEOM) begin
				geom_q <= hwdata[15:0];
			end
		end
	end

	// ************************************************************
	// Taskfile registers with current and previous bytes
	// ************************************************************
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			cnt_cur_q  <= 8'h00;
			cnt_prev_q <= 8'h00;
			sn_cur_q   <= 8'h00;
			sn_prev_q  <= 8'h00;
			cl_cur_q   <= 8'h00;
			cl_prev_q  <= 8'h00;
			ch_cur_q   <= 8'h00;
			ch_prev_q  <= 8'h00;
			devhead_q  <= RVS_RST_DEVHEAD;
		end else if (state_q == RVS_DONE && !err_q[RVS_ER_ABT]) begin
			cnt_cur_q  <= rem_q[7:0];
			cnt_prev_q <= rem_q[15:8];
			sn_cur_q   <= addr_q[7:0];
			cl_cur_q   <= addr_q[15:8];
			ch_cur_q   <= addr_q[23:16];
			if (ext_q) begin
				sn_prev_q <= addr_q[31:24];
				cl_prev_q <= addr_q[39:32];
				ch_prev_q <= addr_q[47:40];
			end else begin
				devhead_q[3:0] <= addr_q[27:24];
			end
		end else if (tf_wr) begin
			// Each write to sector count, sector number or a cylinder byte pushes the older byte into the previous slot
			unique case (wr_addr_q)
				RVS_OFS_SECCNT: begin
					cnt_prev_q <= cnt_cur_q;
					cnt_cur_q  <= wbyte;
				end
				RVS_OFS_SECNUM: begin
					sn_prev_q <= sn_cur_q;
					sn_cur_q  <= wbyte;
				end
				RVS_OFS_CYLLO: begin
					cl_prev_q <= cl_cur_q;
					cl_cur_q  <= wbyte;
				end
				RVS_OFS_CYLHI: begin
					ch_prev_q <= ch_cur_q;
					ch_cur_q  <= wbyte;
				end
				RVS_OFS_DEVHEAD: begin
					devhead_q <= wbyte;
				end
				default: begin
				end
			endcase
		end
	end

	// ************************************************************
	// Verify sequencer
	// ************************************************************
	// Only the address goes to the media engine; no data path exists at all
	assign media_req  = (state_q == RVS_ISSUE);
	assign media_addr = addr_q;
	assign media_chs  = chs_q;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= RVS_IDLE;
			bsy_q   <= 1'b0;
			ext_q   <= 1'b0;
			chs_q   <= 1'b0;
			addr_q  <= 48'h000000000000;
			rem_q   <= 17'h00000;
			err_q   <= 8'h00;
		end else begin
			unique case (state_q)
				RVS_IDLE: begin
					if (go28) begin
						state_q <= RVS_ISSUE;
						bsy_q   <= 1'b1;
						ext_q   <= 1'b0;
						err_q   <= 8'h00;
						chs_q   <= !devhead_q[RVS_DH_LBA];
						addr_q  <= {20'h00000, devhead_q[3:0], ch_cur_q, cl_cur_q,
							sn_cur_q};
						rem_q   <= (cnt_cur_q == 8'h00) ? RVS_CNT28_ZERO
							: {9'h000, cnt_cur_q};
					end else if (go48) begin
						state_q <= RVS_ISSUE;
						bsy_q   <= 1'b1;
						ext_q   <= 1'b1;
						err_q   <= 8'h00;
						chs_q   <= 1'b0;
						addr_q  <= {ch_prev_q, cl_prev_q, sn_prev_q, ch_cur_q, cl_cur_q,
							sn_cur_q};
						rem_q   <= ({cnt_prev_q, cnt_cur_q} == 16'h0000) ? RVS_CNT48_ZERO
							: {1'b0, cnt_prev_q, cnt_cur_q};
					end else if (go_abort) begin
						// Unknown codes abort without touching the taskfile
						state_q <= RVS_DONE;
						bsy_q   <= 1'b1;
						err_q   <= 8'h04;
					end
				end
				RVS_ISSUE: begin
					if (media_done) begin
						if (media_unc) begin
							err_q   <= 8'h40;
							state_q <= RVS_DONE;
						end else if (media_idnf) begin
							err_q   <= 8'h10;
							state_q <= RVS_DONE;
						end else begin
							rem_q <= rem_q - RVS_CNT_ONE;
							if (rem_q == RVS_CNT_ONE) begin
								state_q <= RVS_DONE;
							end else begin
								state_q <= RVS_NEXT;
							end
						end
					end
				end
				RVS_NEXT: begin
					state_q <= RVS_ISSUE;
					if (!chs_q) begin
						addr_q <= addr_q + 48'h000000000001;
					end else if (addr_q[7:0] < geom_q[7:0]) begin
						addr_q[7:0] <= addr_q[7:0] + 8'h01;
					end else begin
						// Sector wraps to 1, then head, then cylinder
						addr_q[7:0] <= 8'h01;
						if (addr_q[27:24] < geom_q[11:8]) begin
							addr_q[27:24] <= addr_q[27:24] + 4'h1;
						end else begin
							addr_q[27:24] <= 4'h0;
							addr_q[23:8]  <= addr_q[23:8] + 16'h0001;
						end
					end
				end
				RVS_DONE: begin
					// Results land on this same edge, so BSY never drops early
					state_q <= RVS_IDLE;
					bsy_q   <= 1'b0;
				end
			endcase
		end
	end

	// ************************************************************
	// Interrupts
	// ************************************************************
	assign irq_set = (state_q == RVS_DONE) ? {|err_q, 1'b1} : 2'h0;
	assign irq_clr = (rd_take && haddr[7:0] == RVS_OFS_IRQ_STAT) ? 2'h3 : 2'h0;

	// A completion in the cycle of the clearing read still survives
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			irq_stat_q <= 2'h0;
		end else begin
			irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
		end
	end

	assign irq = |(irq_stat_q & irq_mask_q);

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	sequence unc_hit_s;
		media_req && media_done && media_unc;
	endsequence

	sequence stop_s;
		(state_q == RVS_DONE && !media_req) ##1 (state_q == RVS_IDLE && !bsy_q);
	endsequence

	sequence sector_ok_s;
		media_req && media_done && !media_unc && !media_idnf;
	endsequence

	sector_count_a: assert property (sector_ok_s |=> rem_q == $past(rem_q) - RVS_CNT_ONE)
		else $error("checked sector not counted off");
	code_start_a: assert property (go28 |=> bsy_q && media_req && !ext_q)
		else $error("28-bit verify code did not start a verify");
	ext_start_a: assert property (go48 |=> media_req && ext_q)
		else $error("48-bit verify code did not start a verify");
	unc_stop_a: assert property (unc_hit_s |=> stop_s)
		else $error("verify went on past an uncorrectable sector");
	count_256_a: assert property (go28 && cnt_cur_q == 8'h00 |=> rem_q == RVS_CNT28_ZERO)
		else $error("zero count did not mean 256 sectors");
	count_64k_a: assert property (go48 && {cnt_prev_q, cnt_cur_q} == 16'h0000
		|=> rem_q == RVS_CNT48_ZERO)
		else $error("zero count did not mean 65536 sectors");
	remain_zero_a: assert property (state_q == RVS_DONE && err_q == 8'h00
		|-> rem_q == 17'h00000)
		else $error("clean completion left sectors unverified");
	err_bits_a: assert property ((err_q & ~RVS_ER_LEGAL) == 8'h00)
		else $error("illegal error bit set");
	status_done_a: assert property ($fell(bsy_q) |-> !status_byte[RVS_ST_DF]
		&& !status_byte[RVS_ST_COR] && status_byte[RVS_ST_ERR] == (err_q != 8'h00))
		else $error("completion status byte wrong");
	busy_hold_a: assert property (state_q != RVS_IDLE |-> bsy_q)
		else $error("busy dropped while verify still running");
	addr_back_a: assert property (state_q == RVS_DONE && !err_q[RVS_ER_ABT]
		|=> sn_cur_q == addr_q[7:0] && cl_cur_q == addr_q[15:8] && ch_cur_q == addr_q[23:16])
		else $error("last sector address not returned");
endmodule

/* File: rtl/rvs_pkg.sv */
package rvs_pkg;

	// ************************************************************
	// Register byte offsets on the AHB-Lite slave
	// ************************************************************
	localparam logic [7:0] RVS_OFS_SECCNT   = 8'h04;
	localparam logic [7:0] RVS_OFS_SECNUM   = 8'h08;
	localparam logic [7:0] RVS_OFS_CYLLO    = 8'h0C;
	localparam logic [7:0] RVS_OFS_CYLHI    = 8'h10;
	localparam logic [7:0] RVS_OFS_DEVHEAD  = 8'h14;
	localparam logic [7:0] RVS_OFS_CMD      = 8'h18;
	localparam logic [7:0] RVS_OFS_ERROR    = 8'h1C;
	localparam logic [7:0] RVS_OFS_DEVCTL   = 8'h20;
	localparam logic [7:0] RVS_OFS_IRQ_STAT = 8'h24;
	localparam logic [7:0] RVS_OFS_IRQ_MASK = 8'h28;
	localparam logic [7:0] RVS_OFS_GEOM     = 8'h2C;

	// ************************************************************
	// Command codes
	// ************************************************************
	localparam logic [6:0] RVS_CMD_VERIFY28_HI = 7'h20;
	localparam logic [7:0] RVS_CMD_VERIFY48    = 8'h42;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int RVS_ST_BSY     = 7;
	localparam int RVS_ST_RDY     = 6;
	localparam int RVS_ST_DF      = 5;
	localparam int RVS_ST_DSC     = 4;
	localparam int RVS_ST_COR     = 2;
	localparam int RVS_ST_ERR     = 0;
	localparam int RVS_ER_UNC     = 6;
	localparam int RVS_ER_IDN     = 4;
	localparam int RVS_ER_ABT     = 2;
	localparam int RVS_DH_LBA     = 6;
	localparam int RVS_DC_HOB     = 7;
	localparam int RVS_IRQ_DONE   = 0;
	localparam int RVS_IRQ_FAIL   = 1;
	localparam logic [7:0] RVS_ER_LEGAL = 8'h54;

	// ************************************************************
	// Reset values and counts
	// ************************************************************
	localparam logic [7:0]  RVS_RST_DEVHEAD = 8'hA0;
	localparam logic [15:0] RVS_RST_GEOM    = 16'h0F3F;
	localparam logic [16:0] RVS_CNT28_ZERO  = 17'h00100;
	localparam logic [16:0] RVS_CNT48_ZERO  = 17'h10000;
	localparam logic [16:0] RVS_CNT_ONE     = 17'h00001;

	typedef enum logic [1:0] {
		RVS_IDLE,
		RVS_ISSUE,
		RVS_NEXT,
		RVS_DONE
	} rvs_state_t;

endpackage

/* File: rtl/rvs_sync3.sv */
`timescale 1ns/1ps
module rvs_sync3 (
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic rstn,
	// Pin and clean level
	input  wire logic pin_in,
	output logic      level_out
);
	logic s1_q;
	logic s2_q;
	logic s3_q;

	// Output moves only when the last two stages agree, filtering one-cycle glitches
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			s1_q      <= 1'b0;
			s2_q      <= 1'b0;
			s3_q      <= 1'b0;
			level_out <= 1'b0;
		end else begin
			s1_q <= pin_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				level_out <= s3_q;
			end
		end
	end
endmodule

/* File: sim/rvs_media_model.sv */
`timescale 1ns/1ps
module rvs_media_model (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rstn,
	// Media link
	input  wire logic        media_req,
	input  wire logic [47:0] media_addr,
	input  wire logic        media_chs,
	output logic             media_done,
	output logic             media_unc,
	output logic             media_idnf,
	// Scenario control and record
	input  wire logic        clr,
	input  wire logic [47:0] fail_addr,
	input  wire logic [1:0]  fail_kind,
	input  wire logic [3:0]  slow,
	output logic [16:0]      n_chk,
	output logic [47:0]      first_addr,
	output logic             first_chs
);
	logic [3:0] wait_q;
	logic       unc_q, idnf_q, junk_q, hit;

	// ****************
	// Sector check
	// ****************
	// Flags mean nothing without done, so they toggle to catch a design sampling early
	assign hit        = media_addr === fail_addr;
	assign media_unc  = media_done ? unc_q : junk_q;
	assign media_idnf = media_done ? idnf_q : ~junk_q;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			wait_q     <= 4'h0;
			media_done <= 1'h0;
			unc_q      <= 1'h0;
			idnf_q     <= 1'h0;
			junk_q     <= 1'h0;
		end else begin
			junk_q     <= ~junk_q;
			media_done <= 1'h0;
			if (media_req && !media_done) begin
				wait_q <= wait_q + 4'h1;
				if (wait_q >= slow) begin
					wait_q     <= 4'h0;
					media_done <= 1'h1;
					unc_q      <= fail_kind[0] && hit;
					idnf_q     <= fail_kind[1] && hit;
				end
			end
		end
	end

	// ****************
	// Record of checks
	// ****************
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			n_chk      <= 17'h0;
			first_addr <= 48'h0;
			first_chs  <= 1'h0;
		end else if (clr) begin
			n_chk <= 17'h0;
		end else if (media_req && media_done) begin
			n_chk <= n_chk + 17'h1;
			if (n_chk == 17'h0) begin
				first_addr <= media_addr;
				first_chs  <= media_chs;
			end
		end
	end
endmodule

/* File: sim/rvs_verify_cmd_tb_top.sv */
`timescale 1ns/1ps
`define CHK(g, e) chk(48'(g), 48'(e));
module rvs_verify_cmd_tb_top;
	import rvs_pkg::*;

	// ****************
	// Signals
	// ****************
	logic        ref_clk, rstn, hsel, hwrite, hreadyout, hresp, irq;
	logic [31:0] haddr, hwdata, hrdata, v;
	logic [1:0]  htrans, fail_kind;
	logic [2:0]  hsize;
	logic        drive_ready_pin, seek_done_pin, clr, first_chs;
	logic        media_req, media_chs, media_done, media_unc, media_idnf;
	logic [47:0] media_addr, fail_addr, first_addr;
	logic [3:0]  slow;
	logic [16:0] n_chk;
	int          num_errors, samples_checked;

	rvs_verify_cmd i_dut (
		.ref_clk(ref_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq),
		.drive_ready_pin(drive_ready_pin), .seek_done_pin(seek_done_pin),
		.media_req(media_req), .media_addr(media_addr), .media_chs(media_chs),
		.media_done(media_done), .media_unc(media_unc), .media_idnf(media_idnf));

	rvs_media_model i_media (
		.ref_clk(ref_clk), .rstn(rstn), .media_req(media_req), .media_addr(media_addr),
		.media_chs(media_chs), .media_done(media_done), .media_unc(media_unc),
		.media_idnf(media_idnf), .clr(clr), .fail_addr(fail_addr), .fail_kind(fail_kind),
		.slow(slow), .n_chk(n_chk), .first_addr(first_addr), .first_chs(first_chs));

	always #5 ref_clk = ~ref_clk;

	// ****************
	// Tasks
	// ****************
	task automatic chk(input logic [47:0] g, input logic [47:0] e);
		samples_checked++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] t=%0t got %0h exp %0h", $time, g, e);
		end
	endtask

	task automatic results;
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic edge_rdy;
		int n;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (hreadyout !== 1'h1 && n < 50);
		if (n >= 50) begin
			num_errors++;
			results();
		end
	endtask

	// One idle cycle before each transfer keeps write then read of a register apart
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] r);
		@(posedge ref_clk);
		hsel   <= 1'h1;
		htrans <= 2'h2;
		haddr  <= {24'h0, a};
		hwrite <= w;
		edge_rdy();
		htrans <= 2'h0;
		hwdata <= d;
		edge_rdy();
		r = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] r;
		xfer(1'h1, a, {24'h0, d}, r);
	endtask

	task automatic rchk(input logic [7:0] a, input logic [15:0] e);
		logic [31:0] r;
		xfer(1'h0, a, 32'h0, r);
		`CHK(r, e)
	endtask

	task automatic wait_idle;
		int n;
		n = 0;
		v = 32'h80;
		while (v[RVS_ST_BSY] !== 1'h0 && n < 1000) begin
			xfer(1'h0, RVS_OFS_CMD, 32'h0, v);
			n++;
		end
		if (n >= 1000) begin
			num_errors++;
			results();
		end
	endtask

	task automatic issue(input logic [7:0] c, s, l, h, d, cmd);
		clr <= 1'h1;
		wr(RVS_OFS_SECCNT, c);
		clr <= 1'h0;
		wr(RVS_OFS_SECNUM, s);
		wr(RVS_OFS_CYLLO, l);
		wr(RVS_OFS_CYLHI, h);
		wr(RVS_OFS_DEVHEAD, d);
		wr(RVS_OFS_CMD, cmd);
	endtask

	task automatic res(input logic [16:0] n, input logic [15:0] sc, sn, cl, ch, st, er);
		wait_idle();
		`CHK(n_chk, n)
		rchk(RVS_OFS_SECCNT, sc);
		rchk(RVS_OFS_SECNUM, sn);
		rchk(RVS_OFS_CYLLO, cl);
		rchk(RVS_OFS_CYLHI, ch);
		rchk(RVS_OFS_CMD, st);
		rchk(RVS_OFS_ERROR, er);
	endtask

	// ****************
	// Sequence
	// ****************
	initial begin
		ref_clk = 1'h0;
		rstn = 1'h0;
		hsel = 1'h0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'h0;
		hsize = 3'h2;
		hwdata = 32'h0;
		drive_ready_pin = 1'h1;
		seek_done_pin = 1'h1;
		clr = 1'h0;
		fail_addr = 48'h0;
		fail_kind = 2'h0;
		slow = 4'h0;
		num_errors = 0;
		samples_checked = 0;
		repeat (16) @(posedge ref_clk);
		rstn <= 1'h1;
		repeat (6) @(posedge ref_clk);
		rchk(RVS_OFS_DEVHEAD, 16'hA0);
		rchk(RVS_OFS_GEOM, 16'h0F3F);
		rchk(RVS_OFS_CMD, 16'h50);
		rchk(RVS_OFS_ERROR, 16'h0);
		rchk(RVS_OFS_IRQ_STAT, 16'h0);
		`CHK(hresp, 1'h0)
		drive_ready_pin <= 1'h0;
		seek_done_pin   <= 1'h0;
		repeat (4) @(posedge ref_clk);
		rchk(RVS_OFS_CMD, 16'h00);
		drive_ready_pin <= 1'h1;
		seek_done_pin   <= 1'h1;
		repeat (4) @(posedge ref_clk);
		rchk(RVS_OFS_CMD, 16'h50);
		wr(8'h3C, 8'hFF);
		rchk(8'h3C, 16'h0);
		$display("test reset done");
		for (int i = 0; i < 2; i++) begin
			issue(8'h03, 8'h10, 8'h20, 8'h30, 8'hE5, 8'h40 + 8'(i));
			res(17'h3, 16'h0, 16'h12, 16'h20, 16'h30, 16'h50, 16'h0);
			`CHK(first_addr, 48'h5302010)
			rchk(RVS_OFS_DEVHEAD, 16'hE5);
			xfer(1'h0, RVS_OFS_IRQ_STAT, 32'h0, v);
			`CHK(v[RVS_IRQ_DONE], 1'h1)
		end
		issue(8'h00, 8'h00, 8'h00, 8'h00, 8'hE0, 8'h41);
		res(17'h100, 16'h0, 16'hFF, 16'h0, 16'h0, 16'h50, 16'h0);
		$display("test lba28 done");
		xfer(1'h0, RVS_OFS_IRQ_STAT, 32'h0, v);
		wr(RVS_OFS_IRQ_MASK, 8'h00);
		fail_kind <= 2'h1;
		fail_addr <= 48'h3000501;
		issue(8'h04, 8'h3E, 8'h05, 8'h00, 8'hA2, 8'h40);
		res(17'h3, 16'h2, 16'h01, 16'h05, 16'h00, 16'h51, 16'h40);
		`CHK(first_chs, 1'h1)
		`CHK(first_addr, 48'h200053E)
		rchk(RVS_OFS_DEVHEAD, 16'hA3);
		`CHK(irq, 1'h0)
		wr(RVS_OFS_IRQ_MASK, 8'h03);
		@(posedge ref_clk);
		`CHK(irq, 1'h1)
		xfer(1'h0, RVS_OFS_IRQ_STAT, 32'h0, v);
		`CHK(v[RVS_IRQ_FAIL], 1'h1)
		@(posedge ref_clk);
		`CHK(irq, 1'h0)
		rchk(RVS_OFS_IRQ_STAT, 16'h0);
		$display("test chs done");
		fail_kind <= 2'h2;
		fail_addr <= 48'h7;
		issue(8'h01, 8'h07, 8'h00, 8'h00, 8'hE0, 8'h40);
		res(17'h1, 16'h1, 16'h07, 16'h0, 16'h0, 16'h51, 16'h10);
		fail_kind <= 2'h1;
		fail_addr <= 48'h665544332213;
		wr(RVS_OFS_SECCNT, 8'h01);
		wr(RVS_OFS_SECNUM, 8'h44);
		wr(RVS_OFS_CYLLO, 8'h55);
		wr(RVS_OFS_CYLHI, 8'h66);
		issue(8'h05, 8'h11, 8'h22, 8'h33, 8'hE0, RVS_CMD_VERIFY48);
		res(17'h3, 16'h3, 16'h13, 16'h22, 16'h33, 16'h51, 16'h40);
		`CHK(first_addr, 48'h665544332211)
		wr(RVS_OFS_DEVCTL, 8'h80);
		rchk(RVS_OFS_SECCNT, 16'h01);
		rchk(RVS_OFS_SECNUM, 16'h44);
		rchk(RVS_OFS_CYLLO, 16'h55);
		rchk(RVS_OFS_CYLHI, 16'h66);
		wr(RVS_OFS_DEVCTL, 8'h00);
		$display("test lba48 done");
		xfer(1'h0, RVS_OFS_IRQ_STAT, 32'h0, v);
		fail_kind <= 2'h0;
		slow <= 4'h8;
		issue(8'h02, 8'h00, 8'h00, 8'h00, 8'hE0, 8'h40);
		xfer(1'h0, RVS_OFS_CMD, 32'h0, v);
		`CHK(v[RVS_ST_BSY], 1'h1)
		`CHK(irq, 1'h0)
		wr(RVS_OFS_DEVHEAD, 8'h07);
		res(17'h2, 16'h0, 16'h01, 16'h0, 16'h0, 16'h50, 16'h0);
		rchk(RVS_OFS_DEVHEAD, 16'hE0);
		wr(RVS_OFS_CMD, 8'h99);
		wait_idle();
		rchk(RVS_OFS_ERROR, 16'h04);
		rchk(RVS_OFS_CMD, 16'h51);
		rchk(RVS_OFS_SECNUM, 16'h01);
		$display("test busy and abort done");
		fail_kind <= 2'h1;
		fail_addr <= 48'h6;
		wr(RVS_OFS_SECCNT, 8'h00);
		wr(RVS_OFS_SECNUM, 8'h00);
		wr(RVS_OFS_CYLLO, 8'h00);
		wr(RVS_OFS_CYLHI, 8'h00);
		issue(8'h00, 8'h05, 8'h00, 8'h00, 8'hE0, RVS_CMD_VERIFY48);
		res(17'h2, 16'hFF, 16'h06, 16'h0, 16'h0, 16'h51, 16'h40);
		wr(RVS_OFS_DEVCTL, 8'h80);
		rchk(RVS_OFS_SECCNT, 16'hFF);
		wr(RVS_OFS_DEVCTL, 8'h00);
		$display("test count zero done");
		results();
	end
endmodule
